// File: atcp_top.sv
// Behaviour
// - Trigger selector zero routes the dedicated trigger pin onto the trigger input.
// - Selector codes one to four route serial port 1-4 receive lines.
// - Codes five, six, seven route comparator one, comparator two, low-voltage detector.
// - Debug halt with freeze bit set holds the counter still.
// - Freeze bit clear lets the counter run during debug halt.
// - Capture select bit set makes a channel capture; clear means compare output.
// - Edge field 01 captures rising edges, 11 captures both edges.
// - With timer enabled, a selected edge copies the counter into capture register.
// - Per-channel enables gate events onto the interrupt and DMA requests.
// - Writing zero to a flag-clear bit clears that pending flag.
// - Output mode 4 toggles the compare output on each match.
// - Counting mode 3 is center-aligned up/down, mode 2 edge-aligned.
// - Complementary bit pairs A and B outputs; single-point bit clear uses both compares in center mode.
// - Output modes 6 and 7 select PWM mode 1 and PWM mode 2.
// - Phase bit zero keeps polarity; one inverts outputs or selects falling input edge.
// - Dead-time enable inserts programmed dead time between complementary transitions.
// - Outputs reach pins only with main output enable set, else inactive.
// - Channel A events assert DMA request source 0x11.
// - Channels 1A-3A and 4 share source 17; 1B-3B share source 18.
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module atcp_top
	import atcp_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        ext_trig_pin,
	input  wire logic [3:0]  uart_rxd,
	input  wire logic        voltage_comparator_one,
	input  wire logic        voltage_comparator_two,
	input  wire logic        low_voltage_detector,
	input  wire logic        cpu_debug_halt,
	input  wire logic [6:0]  cap_pin,
	output logic [6:0]       pwm_out,
	output logic             external_trigger_input,
	output logic             chan_irq,
	output logic             dma_req_src17,
	output logic             dma_req_src18
);

	logic              aw_got_reg, aw_got_next, w_got_reg, w_got_next;
	logic [7:0]        awaddr_reg, awaddr_next;
	logic [31:0]       wdata_reg, wdata_next;
	logic [3:0]        wstrb_reg, wstrb_next;
	logic              awready_reg, awready_next, wready_reg, wready_next;
	logic              bvalid_reg, bvalid_next, arready_reg, arready_next;
	logic              rvalid_reg, rvalid_next;
	logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0]       rdata_reg, rdata_next, rd_val;
	logic              do_wr;
	logic [7:0]        wa, ra;

	logic [15:0]       arr_reg, arr_next, cnt_reg, cnt_next;
	logic              dir_reg, dir_next;
	logic [4:0]        ctrl_reg, ctrl_next;
	logic [9:0]        chcr_reg [4];
	logic [9:0]        chcr_next [4];
	logic [27:0]       fltr_reg, fltr_next;
	logic [9:0]        dtr_reg, dtr_next;
	logic [2:0]        trg_reg, trg_next;
	logic              dbg_reg, dbg_next;
	logic [15:0]       ccr_reg [7];
	logic [15:0]       ccr_next [7];
	logic [6:0]        flags_reg, flags_next, ref_reg, ref_next, out_reg, out_next;
	logic [2:0]        dref_reg, dref_next;
	logic [7:0]        dt_reg [3];
	logic [7:0]        dt_next [3];
	logic [7:0]        s1_reg, s1_next, s2_reg, s2_next, s3_reg, s3_next;
	logic [7:0]        filt_reg, filt_next;
	logic [6:0]        prev_reg, prev_next;
	logic              irq_reg, irq_next, dma_a_reg, dma_a_next, dma_b_reg, dma_b_next;

	logic              etr_raw, run, cs, ph, match, hit, rise, fall;
	logic [2:0]        om;
	logic [1:0]        edg;
	logic [15:0]       cmp;
	logic [6:0]        evt, clr, pre, ie_vec;
	logic [31:0]       tmp;

	assign s_axi_awready          = awready_reg;
	assign s_axi_wready           = wready_reg;
	assign s_axi_bvalid           = bvalid_reg;
	assign s_axi_bresp            = bresp_reg;
	assign s_axi_arready          = arready_reg;
	assign s_axi_rvalid           = rvalid_reg;
	assign s_axi_rdata            = rdata_reg;
	assign s_axi_rresp            = rresp_reg;
	assign pwm_out                = out_reg;
	assign external_trigger_input = filt_reg[7];
	assign chan_irq               = irq_reg;
	assign dma_req_src17          = dma_a_reg;
	assign dma_req_src18          = dma_b_reg;

	assign wa    = {awaddr_reg[7:2], 2'h0};
	assign ra    = {s_axi_araddr[7:2], 2'h0};
	assign do_wr = aw_got_reg && w_got_reg && !bvalid_reg;

	// Trigger source mux ahead of the synchroniser; a glitch on reselect is filtered
	always_comb begin
		case (trg_reg)
			TRG_PIN:   etr_raw = ext_trig_pin;
			TRG_UART1: etr_raw = uart_rxd[0];
			TRG_UART2: etr_raw = uart_rxd[1];
			TRG_UART3: etr_raw = uart_rxd[2];
			TRG_UART4: etr_raw = uart_rxd[3];
			TRG_VC1:   etr_raw = voltage_comparator_one;
			TRG_VC2:   etr_raw = voltage_comparator_two;
			default:   etr_raw = low_voltage_detector;
		endcase
	end

	always_comb begin
		rd_val = 32'h0;
		if (ra == OFS_ARR) rd_val = {16'h0, arr_reg};
		if (ra == OFS_CNT) rd_val = {16'h0, cnt_reg};
		if (ra == OFS_CR) rd_val = {27'h0, ctrl_reg};
		if (ra == OFS_ISR) rd_val = {22'h0, dir_reg, filt_reg[7], 1'b0, flags_reg};
		if (ra == OFS_FLTR) rd_val = {4'h0, fltr_reg};
		if (ra == OFS_DTR) rd_val = {22'h0, dtr_reg};
		if (ra == OFS_TRG) rd_val = {29'h0, trg_reg};
		if (ra == OFS_DBG) rd_val = {31'h0, dbg_reg};
		for (int c = 0; c < 4; c++) begin
			if (ra == CHCR_OFS[c]) rd_val = {22'h0, chcr_reg[c]};
		end
		for (int s = 0; s < NSUB; s++) begin
			if (ra == CCR_OFS[s]) rd_val = {16'h0, ccr_reg[s]};
		end
	end

	// Address and data are accepted in either order; the response waits for both
	always_comb begin
		aw_got_next  = (aw_got_reg || (s_axi_awvalid && awready_reg)) && !do_wr;
		w_got_next   = (w_got_reg || (s_axi_wvalid && wready_reg)) && !do_wr;
		awaddr_next  = (s_axi_awvalid && awready_reg) ? s_axi_awaddr : awaddr_reg;
		wdata_next   = (s_axi_wvalid && wready_reg) ? s_axi_wdata : wdata_reg;
		wstrb_next   = (s_axi_wvalid && wready_reg) ? s_axi_wstrb : wstrb_reg;
		bvalid_next  = do_wr || (bvalid_reg && !s_axi_bready);
		bresp_next   = do_wr ? (mapped(wa) ? RESP_OKAY : RESP_SLVERR) : bresp_reg;
		awready_next = !aw_got_next && !bvalid_next;
		wready_next  = !w_got_next && !bvalid_next;
		rvalid_next  = (s_axi_arvalid && arready_reg) || (rvalid_reg && !s_axi_rready);
		arready_next = !rvalid_next;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		if (s_axi_arvalid && arready_reg) begin
			rdata_next = rd_val;
			rresp_next = mapped(ra) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			aw_got_reg  <= 1'b0;
			w_got_reg   <= 1'b0;
			awaddr_reg  <= 8'h00;
			wdata_reg   <= 32'h0;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			rvalid_reg  <= 1'b0;
			arready_reg <= 1'b0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= RESP_OKAY;
		end else begin
			aw_got_reg  <= aw_got_next;
			w_got_reg   <= w_got_next;
			awaddr_reg  <= awaddr_next;
			wdata_reg   <= wdata_next;
			wstrb_reg   <= wstrb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			rvalid_reg  <= rvalid_next;
			arready_reg <= arready_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	always_comb begin
		arr_next   = arr_reg;
		cnt_next   = cnt_reg;
		dir_next   = dir_reg;
		ctrl_next  = ctrl_reg;
		chcr_next  = chcr_reg;
		fltr_next  = fltr_reg;
		dtr_next   = dtr_reg;
		trg_next   = trg_reg;
		dbg_next   = dbg_reg;
		ccr_next   = ccr_reg;
		ref_next   = ref_reg;
		dref_next  = dref_reg;
		dt_next    = dt_reg;
		out_next   = 7'h00;
		dma_a_next = 1'b0;
		dma_b_next = 1'b0;
		// Three-stage synchroniser; a level counts once stages two and three agree
		s1_next    = {etr_raw, cap_pin};
		s2_next    = s1_reg;
		s3_next    = s2_reg;
		filt_next  = (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
		prev_next  = filt_reg[6:0];
		evt        = 7'h00;
		clr        = 7'h00;
		pre        = 7'h00;
		ie_vec     = 7'h00;
		tmp        = 32'h0;
		cs         = 1'b0;
		ph         = 1'b0;
		om         = 3'h0;
		edg        = 2'h0;
		cmp        = 16'h0;
		match      = 1'b0;
		hit        = 1'b0;
		rise       = 1'b0;
		fall       = 1'b0;

		run = ctrl_reg[CR_EN] && !(cpu_debug_halt && dbg_reg);
		if (run) begin
			if (ctrl_reg[CR_MODE_LO +: 2] == MODE_CENTER) begin
				if (!dir_reg) begin
					if (cnt_reg >= arr_reg) begin
						dir_next = 1'b1;
						cnt_next = (cnt_reg == 16'h0) ? 16'h0 : cnt_reg - 16'h1;
					end else begin
						cnt_next = cnt_reg + 16'h1;
					end
				end else if (cnt_reg == 16'h0) begin
					dir_next = 1'b0;
					cnt_next = 16'h1;
				end else begin
					cnt_next = cnt_reg - 16'h1;
				end
			end else begin
				dir_next = 1'b0;
				cnt_next = (cnt_reg >= arr_reg) ? 16'h0 : cnt_reg + 16'h1;
			end
		end

		// A software write to the counter wins over counting in the same cycle
		if (do_wr) begin
			if (wa == OFS_ARR) begin
				tmp = wmerge({16'h0, arr_reg}, wdata_reg, wstrb_reg);
				arr_next = tmp[15:0];
			end
			if (wa == OFS_CNT) begin
				tmp = wmerge({16'h0, cnt_reg}, wdata_reg, wstrb_reg);
				cnt_next = tmp[15:0];
			end
			if (wa == OFS_CR) begin
				tmp = wmerge({27'h0, ctrl_reg}, wdata_reg, wstrb_reg);
				ctrl_next = tmp[4:0];
			end
			if (wa == OFS_ICR) begin
				clr = ~wdata_reg[6:0] & {7{wstrb_reg[0]}};
			end
			if (wa == OFS_FLTR) begin
				tmp = wmerge({4'h0, fltr_reg}, wdata_reg, wstrb_reg);
				fltr_next = tmp[27:0];
			end
			if (wa == OFS_DTR) begin
				tmp = wmerge({22'h0, dtr_reg}, wdata_reg, wstrb_reg);
				dtr_next = tmp[9:0];
			end
			if (wa == OFS_TRG) begin
				tmp = wmerge({29'h0, trg_reg}, wdata_reg, wstrb_reg);
				trg_next = tmp[2:0];
			end
			if (wa == OFS_DBG) begin
				tmp = wmerge({31'h0, dbg_reg}, wdata_reg, wstrb_reg);
				dbg_next = tmp[0];
			end
			for (int c = 0; c < 4; c++) begin
				if (wa == CHCR_OFS[c]) begin
					tmp = wmerge({22'h0, chcr_reg[c]}, wdata_reg, wstrb_reg);
					chcr_next[c] = tmp[9:0];
				end
			end
			for (int s = 0; s < NSUB; s++) begin
				if (wa == CCR_OFS[s]) begin
					tmp = wmerge({16'h0, ccr_reg[s]}, wdata_reg, wstrb_reg);
					ccr_next[s] = tmp[15:0];
				end
			end
		end

		for (int s = 0; s < NSUB; s++) begin
			cs  = chcr_reg[SUB_CH[s]][CH_CS_A + SUB_B[s]];
			edg = chcr_reg[SUB_CH[s]][CH_EDGE_A + 2*SUB_B[s] +: 2];
			ph  = fltr_reg[FL_STRIDE*s + FL_PHASE];
			om  = fltr_reg[FL_STRIDE*s +: 3];
			ie_vec[s] = chcr_reg[SUB_CH[s]][CH_IE_A + SUB_B[s]];
			rise = (filt_reg[s] ^ ph) && !(prev_reg[s] ^ ph);
			fall = !(filt_reg[s] ^ ph) && (prev_reg[s] ^ ph);
			hit  = ((edg == EDGE_RISE) && rise) || ((edg == EDGE_BOTH) && (rise || fall));
			if (cs && ctrl_reg[CR_EN] && hit) begin
				ccr_next[s] = cnt_reg;
				evt[s] = 1'b1;
			end
			match = !cs && run && (cnt_reg == ccr_reg[s]);
			if (match) begin
				evt[s] = 1'b1;
			end
			// Two-point center mode compares against the partner register on the way down
			cmp = (ctrl_reg[CR_MODE_LO +: 2] == MODE_CENTER && !ctrl_reg[CR_SINGLE_POINT_PWM_SELECT] && dir_reg)
				? ccr_reg[PARTNER[s]] : ccr_reg[s];
			case (om)
				OM_TOGGLE: ref_next[s] = ref_reg[s] ^ match;
				OM_PWM1:   ref_next[s] = (cnt_reg < cmp);
				OM_PWM2:   ref_next[s] = !(cnt_reg < cmp);
				default:   ref_next[s] = ref_reg[s];
			endcase
			if (evt[s] && chcr_reg[SUB_CH[s]][CH_DE_A + SUB_B[s]]) begin
				if (SUB_B[s] == 0) begin
					dma_a_next = 1'b1;
				end else begin
					dma_b_next = 1'b1;
				end
			end
		end

		// Set wins over a clear landing in the same cycle
		flags_next = (flags_reg & ~clr) | evt;
		irq_next   = |(flags_reg & ie_vec);

		pre = ref_reg;
		for (int x = 0; x < 3; x++) begin
			if (ctrl_reg[CR_COMP]) begin
				if (ref_reg[x] != dref_reg[x]) begin
					dref_next[x] = ref_reg[x];
					dt_next[x] = dtr_reg[DT_EN] ? dtr_reg[7:0] : 8'h00;
				end else if (dt_reg[x] != 8'h00) begin
					dt_next[x] = dt_reg[x] - 8'h01;
				end
				// Both legs held low while dead time runs
				pre[x]     = (dt_reg[x] == 8'h00) && dref_reg[x];
				pre[x + 4] = (dt_reg[x] == 8'h00) && !dref_reg[x];
			end else begin
				dt_next[x] = 8'h00;
			end
		end

		for (int s = 0; s < NSUB; s++) begin
			if (dtr_reg[DT_MOE] && !chcr_reg[SUB_CH[s]][CH_CS_A + SUB_B[s]]) begin
				out_next[s] = pre[s] ^ fltr_reg[FL_STRIDE*s + FL_PHASE];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			arr_reg   <= RST_ARR;
			cnt_reg   <= 16'h0;
			dir_reg   <= 1'b0;
			ctrl_reg  <= RST_CR;
			chcr_reg  <= '{default: 10'h000};
			fltr_reg  <= 28'h0;
			dtr_reg   <= RST_DTR;
			trg_reg   <= TRG_PIN;
			dbg_reg   <= 1'b0;
			ccr_reg   <= '{default: 16'h0};
			flags_reg <= 7'h00;
			ref_reg   <= 7'h00;
			dref_reg  <= 3'h0;
			dt_reg    <= '{default: 8'h00};
			out_reg   <= 7'h00;
			s1_reg    <= 8'h00;
			s2_reg    <= 8'h00;
			s3_reg    <= 8'h00;
			filt_reg  <= 8'h00;
			prev_reg  <= 7'h00;
			irq_reg   <= 1'b0;
			dma_a_reg <= 1'b0;
			dma_b_reg <= 1'b0;
		end else begin
			arr_reg   <= arr_next;
			cnt_reg   <= cnt_next;
			dir_reg   <= dir_next;
			ctrl_reg  <= ctrl_next;
			chcr_reg  <= chcr_next;
			fltr_reg  <= fltr_next;
			dtr_reg   <= dtr_next;
			trg_reg   <= trg_next;
			dbg_reg   <= dbg_next;
			ccr_reg   <= ccr_next;
			flags_reg <= flags_next;
			ref_reg   <= ref_next;
			dref_reg  <= dref_next;
			dt_reg    <= dt_next;
			out_reg   <= out_next;
			s1_reg    <= s1_next;
			s2_reg    <= s2_next;
			s3_reg    <= s3_next;
			filt_reg  <= filt_next;
			prev_reg  <= prev_next;
			irq_reg   <= irq_next;
			dma_a_reg <= dma_a_next;
			dma_b_reg <= dma_b_next;
		end
	end

endmodule

`default_nettype wire

// File: atcp_pkg.sv
package atcp_pkg;

	localparam int CNT_W = 16;
	localparam int NSUB  = 7;

	localparam logic [7:0] OFS_ARR  = 8'h00;
	localparam logic [7:0] OFS_CNT  = 8'h04;
	localparam logic [7:0] OFS_CR   = 8'h0C;
	localparam logic [7:0] OFS_ISR  = 8'h10;
	localparam logic [7:0] OFS_ICR  = 8'h14;
	localparam logic [7:0] OFS_FLTR = 8'h1C;
	localparam logic [7:0] OFS_DTR  = 8'h30;
	localparam logic [7:0] OFS_TRG  = 8'h60;
	localparam logic [7:0] OFS_DBG  = 8'h64;
	localparam logic [7:0] SCALAR_OFS [9] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h1C,
		8'h30, 8'h60, 8'h64};
	localparam logic [7:0] CHCR_OFS [4] = '{8'h24, 8'h28, 8'h2C, 8'h58};
	// Sub-channel order: 1A 2A 3A 4 1B 2B 3B
	localparam logic [7:0] CCR_OFS [7] = '{8'h3C, 8'h44, 8'h4C, 8'h54, 8'h40, 8'h48, 8'h50};
	localparam int SUB_CH [7]  = '{0, 1, 2, 3, 0, 1, 2};
	localparam int SUB_B [7]   = '{0, 0, 0, 0, 1, 1, 1};
	localparam int PARTNER [7] = '{4, 5, 6, 3, 0, 1, 2};

	localparam int CR_EN      = 0;
	localparam int CR_MODE_LO = 1;
	localparam int CR_COMP    = 3;
	localparam int CR_SINGLE_POINT_PWM_SELECT   = 4;
	localparam logic [1:0] MODE_EDGE   = 2'h2;
	localparam logic [1:0] MODE_CENTER = 2'h3;

	localparam int CH_CS_A   = 0;
	localparam int CH_EDGE_A = 2;
	localparam int CH_IE_A   = 6;
	localparam int CH_DE_A   = 8;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	localparam int FL_STRIDE = 4;
	localparam int FL_PHASE  = 3;
	localparam logic [2:0] OM_TOGGLE = 3'h4;
	localparam logic [2:0] OM_PWM1   = 3'h6;
	localparam logic [2:0] OM_PWM2   = 3'h7;

	localparam int DT_EN  = 8;
	localparam int DT_MOE = 9;
	localparam int ISR_ETR = 8;

	localparam logic [2:0] TRG_PIN   = 3'h0;
	localparam logic [2:0] TRG_UART1 = 3'h1;
	localparam logic [2:0] TRG_UART2 = 3'h2;
	localparam logic [2:0] TRG_UART3 = 3'h3;
	localparam logic [2:0] TRG_UART4 = 3'h4;
	localparam logic [2:0] TRG_VC1   = 3'h5;
	localparam logic [2:0] TRG_VC2   = 3'h6;

	localparam logic [15:0] RST_ARR  = 16'hFFFF;
	localparam logic [4:0]  RST_CR   = 5'h00;
	localparam logic [9:0]  RST_DTR  = 10'h000;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[8*i +: 8] = d[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		logic m;
		m = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (a == SCALAR_OFS[i]) begin
				m = 1'b1;
			end
		end
		for (int i = 0; i < 4; i++) begin
			if (a == CHCR_OFS[i]) begin
				m = 1'b1;
			end
		end
		for (int i = 0; i < 7; i++) begin
			if (a == CCR_OFS[i]) begin
				m = 1'b1;
			end
		end
		return m;
	endfunction

endpackage

// File: atcp_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module atcp_monitor (
	input wire logic       ref_clk,
	input wire logic       srst,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic [6:0] pwm_out,
	input wire logic       chan_irq,
	input wire logic       dma_req_src17,
	input wire logic       dma_req_src18
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	a_reset_quiet: assert property (
		$fell(srst) |-> pwm_out == 7'h00 && !chan_irq && !dma_req_src17 && !dma_req_src18)
		else $error("outputs not idle after reset");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response not two cycles after acceptance");
	a_aw_refused: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
		else $error("write address reopened before response");
	// Ready rises at the response edge itself, so the next write may follow at once
	a_b_reopen: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write channels not reopened after response");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data not one cycle after address");
	a_r_reopen: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read address not reopened after data");
	a_dma_a_pulse: assert property (dma_req_src17 |=> !dma_req_src17)
		else $error("source 17 request wider than one cycle");
	a_dma_b_pulse: assert property (dma_req_src18 |=> !dma_req_src18)
		else $error("source 18 request wider than one cycle");
endmodule

bind atcp_top atcp_monitor u_mon (.*);
`default_nettype wire

// File: atcp_peer_model.sv
`timescale 1ns/1ps
`default_nettype none

module atcp_peer_model (
	input  wire logic       ref_clk,
	input  wire logic       srst,
	input  wire logic [6:0] pin_req,
	input  wire logic [7:0] trig_req,
	input  wire logic       dma_req_src17,
	input  wire logic       dma_req_src18,
	output logic [6:0]      cap_pin,
	output logic            ext_trig_pin,
	output logic [3:0]      uart_rxd,
	output logic            voltage_comparator_one,
	output logic            voltage_comparator_two,
	output logic            low_voltage_detector,
	output logic [7:0]      dma_a_cnt,
	output logic [7:0]      dma_b_cnt
);
	// Sources are plain levels; the timer synchronises them itself
	assign cap_pin                = pin_req;
	assign ext_trig_pin           = trig_req[0];
	assign uart_rxd               = trig_req[4:1];
	assign voltage_comparator_one = trig_req[5];
	assign voltage_comparator_two = trig_req[6];
	assign low_voltage_detector   = trig_req[7];

	// One block transfer per request pulse; the count is the destination index
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			dma_a_cnt <= 8'h00;
			dma_b_cnt <= 8'h00;
		end else begin
			dma_a_cnt <= dma_a_cnt + {7'h00, dma_req_src17};
			dma_b_cnt <= dma_b_cnt + {7'h00, dma_req_src18};
		end
	end
endmodule

`default_nettype wire

// File: test_advanced_timer_capture_pwm.sv
`timescale 1ns/1ps
`default_nettype none

module test_advanced_timer_capture_pwm
	import atcp_pkg::*;
;
	typedef struct {logic [7:0] a; logic [31:0] z, w, r; logic [1:0] s;} atcp_row_t;
	typedef struct {logic [31:0] f, d; logic e;} atcp_pwm_t;

	logic        ref_clk, srst, cpu_debug_halt, chan_irq, dma_req_src17, dma_req_src18;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, trig_req, dma_a_cnt, dma_b_cnt;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb, uart_rxd;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        ext_trig_pin, external_trigger_input, low_voltage_detector;
	logic        voltage_comparator_one, voltage_comparator_two;
	logic [1:0]  s_axi_bresp, s_axi_rresp, s;
	logic [6:0]  cap_pin, pin_req, pwm_out;
	int          fail_count, cmp_count;

	atcp_row_t rows [7] = '{
		'{OFS_ARR, 32'(RST_ARR), 32'h1234_0064, 32'h0000_0064, RESP_OKAY},
		'{OFS_CR, 32'h0, 32'h0000_0005, 32'h0000_0005, RESP_OKAY},
		'{OFS_TRG, 32'h0, 32'h0000_00FF, 32'h0000_0007, RESP_OKAY},
		'{OFS_DTR, 32'(RST_DTR), 32'h0000_0FFF, 32'h0000_03FF, RESP_OKAY},
		'{OFS_ICR, 32'h0, 32'h0000_00FF, 32'h0, RESP_OKAY},
		'{OFS_DBG, 32'h0, 32'h1, 32'h1, RESP_OKAY},
		'{8'h08, 32'h0, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR}};
	// Counter frozen at 0x42 below compare 0x50, so the reference is high in PWM mode 1 and low in PWM mode 2
	atcp_pwm_t pw [5] = '{'{32'h60, 32'h000, 1'b0}, '{32'h60, 32'h200, 1'b1},
		'{32'h70, 32'h200, 1'b0}, '{32'hE0, 32'h200, 1'b0}, '{32'hF0, 32'h200, 1'b1}};

	atcp_top DUT (.*);
	atcp_peer_model u_peer (.*);

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_awaddr  <= a;
		s_axi_wdata   <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 40);
		r = s_axi_bresp;
		if (n >= 40) fail_count++;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 40);
		v = s_axi_rdata;
		r = s_axi_rresp;
		if (n >= 40) fail_count++;
	endtask

	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Whole run is a few hundred cycles; this leaves wide margin
	initial begin
		#200us;
		fail_count++;
		end_sim;
	end

	initial begin
		srst = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, cpu_debug_halt} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3F;
		trig_req = 8'h00;
		pin_req = 7'h00;
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		foreach (rows[i]) begin
			rd(rows[i].a, d, s);
			chk(d, rows[i].z);
			wr(rows[i].a, rows[i].w, s);
			chk(32'(s), 32'(rows[i].s));
			rd(rows[i].a, d, s);
			chk(d, rows[i].r);
			chk(32'(s), 32'(rows[i].s));
		end
		for (int k = 0; k < 8; k++) begin
			wr(OFS_TRG, 32'(k), s);
			trig_req <= 8'h01 << k;
			repeat (8) @(posedge ref_clk);
			chk(32'(external_trigger_input), 32'h1);
			trig_req <= ~(8'h01 << k);
			repeat (8) @(posedge ref_clk);
			chk(32'(external_trigger_input), 32'h0);
		end
		cpu_debug_halt <= 1'b1;
		wr(OFS_CNT, 32'h42, s);
		repeat (10) @(posedge ref_clk);
		rd(OFS_CNT, d, s);
		chk(d, 32'h42);
		wr(OFS_DBG, 32'h0, s);
		rd(OFS_CNT, d, s);
		chk(32'(d !== 32'h42), 32'h1);
		wr(OFS_DBG, 32'h1, s);
		wr(OFS_CNT, 32'h42, s);
		wr(OFS_ICR, 32'h0, s);
		wr(CHCR_OFS[0], 32'h145, s);
		pin_req[0] <= 1'b1;
		repeat (12) @(posedge ref_clk);
		chk(32'(dma_a_cnt), 32'h1);
		chk(32'(chan_irq), 32'h1);
		rd(CCR_OFS[0], d, s);
		chk(d, 32'h42);
		pin_req[0] <= 1'b0;
		repeat (12) @(posedge ref_clk);
		chk(32'(dma_a_cnt), 32'h1);
		rd(OFS_ISR, d, s);
		chk(32'(d[0]), 32'h1);
		wr(OFS_ICR, 32'hFE, s);
		repeat (2) @(posedge ref_clk);
		rd(OFS_ISR, d, s);
		chk(32'(d[0]), 32'h0);
		chk(32'(chan_irq), 32'h0);
		wr(CHCR_OFS[2], 32'h232, s);
		pin_req[6] <= 1'b1;
		repeat (12) @(posedge ref_clk);
		pin_req[6] <= 1'b0;
		repeat (12) @(posedge ref_clk);
		chk(32'(dma_b_cnt), 32'h2);
		// Third both-edge capture closes one period of the measured train
		pin_req[6] <= 1'b1;
		repeat (12) @(posedge ref_clk);
		chk(32'(dma_b_cnt), 32'h3);
		rd(CCR_OFS[6], d, s);
		chk(d, 32'h42);
		wr(CCR_OFS[1], 32'h50, s);
		foreach (pw[i]) begin
			wr(OFS_FLTR, pw[i].f, s);
			wr(OFS_DTR, pw[i].d, s);
			repeat (4) @(posedge ref_clk);
			chk(32'(pwm_out[1]), 32'(pw[i].e));
		end
		end_sim;
	end
endmodule

`default_nettype wire
